/* File: core/cep_port.sv */
`timescale 1ns/1ps
// Operation
// - Input-only variant: all four bits inputs, pull-downs per option.
// - Input data register at 0EH reads pins; io option makes it I/O.
// - Direction register at 01H resets 0000; 1 output, 0 input, I/O only.
// - Shared data register at 04H resets 0000; writes drive output latch.
// - Pull-downs apply only to bits configured as inputs.
// - Three analog modes chosen by amplifier and two comparator options.
// - All analog options clear: plain digital port, read-zero options ignored.
// - Bit-1 read-zero set reads 0, else pin 1 level.
// - Bit-3 read-zero governs bit 3 the same way.
// - Comparator 1 enabled: bit 0 reads comparator 1 output.
// - Comparator 2 enabled, others clear: bit 2 reads comparator 2 output.
// - Both comparator options with the amplifier clear give two-comparator mode; each may stand alone.
// - Comparator-plus-amplifier: bits 2,3 read 0, bit 0 comparator, bit 1 option.
// - Build option picks output-only or input-only; another picks per-bit I/O.
// - Output-only variant: all bits outputs, data writes drive pins.
module cep_port #(
  parameter int unsigned WIDTH = cep_pkg::PORT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [cep_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // Build-time options
  input wire logic output_or_input_variant_select,
  input wire logic shared_port_io_option,
  input wire logic input_variant_io_option,
  input wire logic amplifier_enable,
  input wire logic comparator_one_enable,
  input wire logic comparator_two_enable,
  input wire logic bit1_read_zero_option,
  input wire logic bit3_read_zero_option,
  input wire logic gain_enable_function,
  input wire logic [WIDTH-1:0] pull_down_option,
  // Pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pull_down_en,
  // Analog blocks
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  output logic amplifier_on,
  output logic comparator_one_on,
  output logic comparator_two_on,
  output logic config_conflict
);

  typedef struct packed {
    logic [3:0] direction;
    logic [3:0] out_latch;
    logic [3:0] rdata;
    logic taken;
    logic [1:0] variant;
    logic [1:0] analog_mode;
    logic amp;
    logic cmp1;
    logic cmp2;
    logic rz1;
    logic rz3;
    logic conflict;
  } cep_state_t;

  cep_state_t st;
  cep_state_t next_st;

  logic [3:0] plain_value;
  logic [3:0] port_value;
  logic [3:0] status_value;

  // Variant from the build options
  function automatic logic [1:0] variant_of(input logic sel_out, input logic io_shared,
                                            input logic io_input);
    if (io_shared || (!sel_out && io_input)) begin
      variant_of = 2'(cep_pkg::CEP_BIDIR);
    end else if (sel_out) begin
      variant_of = 2'(cep_pkg::CEP_OUTPUT_ONLY);
    end else begin
      variant_of = 2'(cep_pkg::CEP_INPUT_ONLY);
    end
  endfunction

  // Analog sharing mode from the three enables
  function automatic logic [1:0] analog_of(input logic amp, input logic c1, input logic c2);
    if (amp && c1) begin
      analog_of = 2'(cep_pkg::CEP_CMP_AMP);
    end else if (amp) begin
      analog_of = 2'(cep_pkg::CEP_SINGLE_AMP);
    end else if (c1 || c2) begin
      analog_of = 2'(cep_pkg::CEP_COMPARATORS);
    end else begin
      analog_of = 2'(cep_pkg::CEP_DIGITAL);
    end
  endfunction

  // Plain digital read: latch for outputs, pin for inputs
  always_comb begin
    unique case (cep_pkg::cep_variant_t'(st.variant))
      cep_pkg::CEP_OUTPUT_ONLY: plain_value = st.out_latch;
      cep_pkg::CEP_BIDIR: plain_value = (st.direction & st.out_latch)
                                      | (~st.direction & pin_in);
      default: plain_value = pin_in;
    endcase
  end

  cep_read_mux u_read_mux (
    .analog_mode(st.analog_mode),
    .comparator_one_enable(st.cmp1),
    .comparator_two_enable(st.cmp2),
    .bit1_read_zero_option(st.rz1),
    .bit3_read_zero_option(st.rz3),
    .plain_value(plain_value),
    .pin_in(pin_in),
    .comparator_one_out(comparator_one_out),
    .comparator_two_out(comparator_two_out),
    .read_value(port_value)
  );

  cep_pin_ctrl #(
    .WIDTH(WIDTH)
  ) u_pin_ctrl (
    .variant(st.variant),
    .direction(st.direction),
    .pull_down_option(pull_down_option),
    .pin_oe(pin_oe),
    .pull_down_en(pull_down_en)
  );

  always_comb begin
    status_value = cep_pkg::RST_ZERO;
    status_value[cep_pkg::ST_MODE_HI:cep_pkg::ST_MODE_LO] = st.analog_mode;
    status_value[cep_pkg::ST_IO_ACTIVE] = (st.variant == 2'(cep_pkg::CEP_BIDIR));
    status_value[cep_pkg::ST_CONFLICT] = st.conflict;
  end

  always_comb begin
    next_st = st;
    // Options captured once after reset release, then held
    if (!st.taken) begin
      next_st.taken = 1'b1;
      next_st.variant = variant_of(output_or_input_variant_select, shared_port_io_option,
                                   input_variant_io_option);
      next_st.analog_mode = analog_of(amplifier_enable, comparator_one_enable,
                                      comparator_two_enable);
      next_st.amp = amplifier_enable;
      next_st.cmp1 = comparator_one_enable;
      next_st.cmp2 = comparator_two_enable;
      next_st.rz1 = bit1_read_zero_option;
      next_st.rz3 = bit3_read_zero_option;
      // Settings the software side must avoid
      next_st.conflict = (amplifier_enable & comparator_one_enable & comparator_two_enable)
                       | (amplifier_enable & gain_enable_function);
    end
    if (reg_wr) begin
      unique case (reg_addr)
        cep_pkg::OFS_DIRECTION: begin
          // Direction only matters in the I/O variant
          next_st.direction = reg_wdata;
        end
        cep_pkg::OFS_SHARED_DATA, cep_pkg::OFS_INPUT_DATA: begin
          next_st.out_latch = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    next_st.rdata = cep_pkg::RST_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        cep_pkg::OFS_DIRECTION: next_st.rdata = st.direction;
        cep_pkg::OFS_SHARED_DATA: next_st.rdata = port_value;
        cep_pkg::OFS_INPUT_DATA: next_st.rdata = port_value;
        cep_pkg::OFS_MODE_STATUS: next_st.rdata = status_value;
        default: next_st.rdata = cep_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.direction <= cep_pkg::RST_DIRECTION;
      st.out_latch <= cep_pkg::RST_SHARED_DATA;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pin_out = st.out_latch;
  assign amplifier_on = st.amp && (st.variant == 2'(cep_pkg::CEP_BIDIR));
  assign comparator_one_on = st.cmp1 && (st.variant == 2'(cep_pkg::CEP_BIDIR));
  assign comparator_two_on = st.cmp2 && (st.variant == 2'(cep_pkg::CEP_BIDIR))
                           && (st.analog_mode == 2'(cep_pkg::CEP_COMPARATORS));
  assign config_conflict = st.conflict;

endmodule

/* File: include/cep_pkg.sv */
package cep_pkg;

  localparam int unsigned PORT_W = 4;
  localparam int unsigned ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] OFS_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_SHARED_DATA = 4'h4;
  localparam logic [3:0] OFS_INPUT_DATA = 4'he;
  localparam logic [3:0] OFS_MODE_STATUS = 4'hf;

  // Reset values
  localparam logic [3:0] RST_DIRECTION = 4'h0;
  localparam logic [3:0] RST_SHARED_DATA = 4'h0;
  localparam logic [3:0] RST_ZERO = 4'h0;

  // Data bit positions tied to the analog blocks
  localparam int unsigned BIT_CMP1 = 0;
  localparam int unsigned BIT_RZ1 = 1;
  localparam int unsigned BIT_CMP2 = 2;
  localparam int unsigned BIT_RZ3 = 3;

  // Mode status field positions
  localparam int unsigned ST_MODE_LO = 0;
  localparam int unsigned ST_MODE_HI = 1;
  localparam int unsigned ST_IO_ACTIVE = 2;
  localparam int unsigned ST_CONFLICT = 3;

  // Option capture delay after reset release, in cycles
  localparam int unsigned OPT_CAPTURE_CYCLES = 1;

  typedef enum logic [1:0] {
    CEP_INPUT_ONLY,
    CEP_OUTPUT_ONLY,
    CEP_BIDIR
  } cep_variant_t;

  typedef enum logic [1:0] {
    CEP_DIGITAL,
    CEP_SINGLE_AMP,
    CEP_COMPARATORS,
    CEP_CMP_AMP
  } cep_analog_t;

endpackage

/* File: core/cep_pin_ctrl.sv */
`timescale 1ns/1ps
module cep_pin_ctrl #(
  parameter int unsigned WIDTH = 4
) (
  // Configuration
  input wire logic [1:0] variant,
  input wire logic [WIDTH-1:0] direction,
  input wire logic [WIDTH-1:0] pull_down_option,
  // Pin control
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pull_down_en
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        unique case (cep_pkg::cep_variant_t'(variant))
          cep_pkg::CEP_OUTPUT_ONLY: pin_oe[i] = 1'b1;
          cep_pkg::CEP_BIDIR: pin_oe[i] = direction[i];
          default: pin_oe[i] = 1'b0;
        endcase
        // Pull-down only where the pin is an input
        pull_down_en[i] = pull_down_option[i] & ~pin_oe[i];
      end
    end
  endgenerate

endmodule

/* File: core/cep_read_mux.sv */
`timescale 1ns/1ps
module cep_read_mux (
  // Configuration
  input wire logic [1:0] analog_mode,
  input wire logic comparator_one_enable,
  input wire logic comparator_two_enable,
  input wire logic bit1_read_zero_option,
  input wire logic bit3_read_zero_option,
  // Sources
  input wire logic [3:0] plain_value,
  input wire logic [3:0] pin_in,
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  // Result
  output logic [3:0] read_value
);

  always_comb begin
    read_value = plain_value;
    if (cep_pkg::cep_analog_t'(analog_mode) == cep_pkg::CEP_CMP_AMP) begin
      read_value[cep_pkg::BIT_CMP1] = comparator_one_out;
      read_value[cep_pkg::BIT_RZ1] = bit1_read_zero_option ? 1'b0
                                   : pin_in[cep_pkg::BIT_RZ1];
      read_value[cep_pkg::BIT_CMP2] = 1'b0;
      read_value[cep_pkg::BIT_RZ3] = 1'b0;
    end else if (cep_pkg::cep_analog_t'(analog_mode) == cep_pkg::CEP_COMPARATORS) begin
      if (comparator_one_enable) begin
        read_value[cep_pkg::BIT_CMP1] = comparator_one_out;
        read_value[cep_pkg::BIT_RZ1] = bit1_read_zero_option ? 1'b0
                                     : pin_in[cep_pkg::BIT_RZ1];
      end
      if (comparator_two_enable) begin
        read_value[cep_pkg::BIT_CMP2] = comparator_two_out;
        read_value[cep_pkg::BIT_RZ3] = bit3_read_zero_option ? 1'b0
                                     : pin_in[cep_pkg::BIT_RZ3];
      end
    end
  end

endmodule

/* File: bench/cep_port_checker.sv */
`timescale 1ns/1ps
module cep_port_checker #(
  parameter int unsigned WIDTH = 4
) (
  // Clock, reset and register port
  input wire logic mclk, rstn, reg_wr, reg_rd,
  input wire logic [cep_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [3:0] reg_wdata, reg_rdata,
  // Options
  input wire logic output_or_input_variant_select, shared_port_io_option,
  input wire logic input_variant_io_option, amplifier_enable, bit1_read_zero_option,
  input wire logic comparator_one_enable, comparator_two_enable,
  input wire logic bit3_read_zero_option, gain_enable_function,
  // Analog block enables
  input wire logic amplifier_on, comparator_one_on, comparator_two_on, config_conflict,
  // Pins and comparators
  input wire logic comparator_one_out, comparator_two_out,
  input wire logic [WIDTH-1:0] pull_down_option, pin_in, pin_out, pin_oe, pull_down_en
);
  logic [1:0] age;
  logic up, io, rd4;
  logic [WIDTH-1:0] plain;
  // Options are in force from the first edge after release; up rises at the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) age <= 2'h0;
    else if (!age[1]) age <= age + 2'h1;
  end
  assign up = age[1];
  assign io = shared_port_io_option | (!output_or_input_variant_select & input_variant_io_option);
  assign rd4 = up && reg_rd && reg_addr == cep_pkg::OFS_SHARED_DATA;
  assign plain = (pin_oe & pin_out) | (~pin_oe & pin_in);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_pull_inputs: assert property (pull_down_en == (pull_down_option & ~pin_oe))
    else $error("pull-down active on a driven pin");
  a_latch_write: assert property (up && reg_wr && reg_addr == cep_pkg::OFS_SHARED_DATA
    |=> pin_out == $past(reg_wdata)) else $error("data write did not reach pins");
  a_dir_enable: assert property (up && io && reg_wr && reg_addr == cep_pkg::OFS_DIRECTION
    |=> pin_oe == $past(reg_wdata)) else $error("direction write did not set enables");
  a_input_only: assert property (up && !io && !output_or_input_variant_select
    |-> pin_oe == '0) else $error("input-only port drives a pin");
  a_output_only: assert property (up && !io && output_or_input_variant_select
    |-> &pin_oe) else $error("output-only port leaves a pin undriven");
  a_read_plain: assert property (rd4 && !amplifier_enable && !comparator_one_enable
    && !comparator_two_enable |=> reg_rdata == $past(plain)) else $error("plain read wrong");
  a_read_cmp_one: assert property (rd4 && comparator_one_enable
    |=> reg_rdata[0] == $past(comparator_one_out)) else $error("bit 0 not comparator one");
  a_read_zero_one: assert property (rd4 && comparator_one_enable && bit1_read_zero_option
    |=> !reg_rdata[1]) else $error("bit 1 not forced to zero");
  a_read_cmp_two: assert property (rd4 && comparator_two_enable && !amplifier_enable
    |=> reg_rdata[2] == $past(comparator_two_out)) else $error("bit 2 not comparator two");
  a_cmp_amp_zero: assert property (rd4 && amplifier_enable && comparator_one_enable
    |=> reg_rdata[3:2] == 2'h0) else $error("upper bits not zero with amplifier");
  a_read_zero_three: assert property (rd4 && comparator_two_enable && !amplifier_enable
    && bit3_read_zero_option |=> !reg_rdata[3]) else $error("bit 3 not forced to zero");
  a_amp_enable: assert property (up
    |-> amplifier_on == (amplifier_enable && io)) else $error("amplifier enable wrong");
  a_cmp_one_on: assert property (up
    |-> comparator_one_on == (comparator_one_enable && io))
    else $error("comparator one enable wrong");
  a_cmp_two_on: assert property (up
    |-> comparator_two_on == (comparator_two_enable && io && !amplifier_enable))
    else $error("comparator two enable wrong");
  a_conflict_flag: assert property (up
    |-> config_conflict == (amplifier_enable && (gain_enable_function
    || (comparator_one_enable && comparator_two_enable)))) else $error("conflict flag wrong");
endmodule
bind cep_port cep_port_checker #(.WIDTH(WIDTH)) i_chk (.*);

/* File: bench/cep_pins_model.sv */
`timescale 1ns/1ps
module cep_pins_model (
  input wire logic [3:0] pin_out, pin_oe, pull_down_en, ext, ext_en,
  output logic [3:0] pin_in
);
  // Released pins fall to the pull-down, else float away from the last level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext)
    | (~pin_oe & ~ext_en & ~pull_down_en & ~ext);
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
  logic c1o = 1'b0, c2o = 1'b0;
  logic [3:0] reg_addr = 4'h0, reg_wdata = 4'h0, reg_rdata, exp_v, dir_m, lat_m;
  logic [3:0] ext = 4'h0, ext_en = 4'hf, pd_opt = 4'h0, pin_in, pin_out, pin_oe, pd_en;
  logic [8:0] opt = 9'h000;
  logic [31:0] r;
  logic [3:0] expq[$];
  int seed = 32'h82d73cea;
  int failures = 0, n_tests = 0, cyc = 0;
  // Options: sel, shared io, input io, amp, cmp1, cmp2, rz1, rz3, gain
  logic [8:0] cfg [11] = '{9'h006, 9'h100, 9'h086, 9'h040, 9'h0a0, 9'h098, 9'h09e,
    9'h094, 9'h088, 9'h0b0, 9'h0b4};
  always #5 mclk = ~mclk;
  cep_port i_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .output_or_input_variant_select(opt[8]), .shared_port_io_option(opt[7]),
    .input_variant_io_option(opt[6]), .amplifier_enable(opt[5]),
    .comparator_one_enable(opt[4]), .comparator_two_enable(opt[3]),
    .bit1_read_zero_option(opt[2]), .bit3_read_zero_option(opt[1]),
    .gain_enable_function(opt[0]), .pull_down_option(pd_opt), .pin_in, .pin_out, .pin_oe,
    .pull_down_en(pd_en), .comparator_one_out(c1o), .comparator_two_out(c2o),
    .amplifier_on(), .comparator_one_on(), .comparator_two_on(), .config_conflict());
  cep_pins_model i_pins (.pin_out, .pin_oe, .pull_down_en(pd_en), .ext, .ext_en, .pin_in);
  function automatic logic [3:0] expect_rd(input logic [3:0] a);
    logic io;
    logic [3:0] oe, v;
    logic [1:0] m;
    io = opt[7] | (~opt[8] & opt[6]);
    oe = io ? dir_m : {4{~io & opt[8]}};
    v = (oe & lat_m) | (~oe & ext_en & ext) | (~oe & ~ext_en & ~pd_opt & ~ext);
    if (opt[5] & opt[4]) v = {2'b00, opt[2] ? 1'b0 : v[1], c1o};
    else if (!opt[5]) begin
      if (opt[4]) v[1:0] = {opt[2] ? 1'b0 : v[1], c1o};
      if (opt[3]) v[3:2] = {opt[1] ? 1'b0 : v[3], c2o};
    end
    // Status: conflict, I/O variant, analog mode
    m = (opt[5] & opt[4]) ? 2'h3 : opt[5] ? 2'h1 : (opt[4] | opt[3]) ? 2'h2 : 2'h0;
    if (a == cep_pkg::OFS_DIRECTION) v = dir_m;
    else if (a == cep_pkg::OFS_MODE_STATUS) v = {opt[5] & (opt[0] | (opt[4] & opt[3])), io, m};
    else if (a != cep_pkg::OFS_SHARED_DATA && a != cep_pkg::OFS_INPUT_DATA) v = 4'h0;
    return v;
  endfunction
  task automatic op(input logic w, input logic rd, input logic [3:0] a, input logic [3:0] d);
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    if (w && a == cep_pkg::OFS_DIRECTION) dir_m = d;
    if (w && (a == cep_pkg::OFS_SHARED_DATA || a == cep_pkg::OFS_INPUT_DATA)) lat_m = d;
    if (rd) expq.push_back(expect_rd(a));
    @(posedge mclk);
  endtask
  task automatic end_sim;
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    cyc++;
    if (rd_q) begin
      n_tests++;
      exp_v = expq.pop_front();
      if (reg_rdata !== exp_v) begin
        failures++;
        $display("mismatch t=%0t got=%h exp=%h", $time, reg_rdata, exp_v);
      end
    end
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    for (int k = 0; k < 11; k++) begin
      rstn <= 1'b0;
      opt <= cfg[k];
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      dir_m = cep_pkg::RST_DIRECTION;
      lat_m = cep_pkg::RST_SHARED_DATA;
      repeat (2) @(posedge mclk);
      op(1'b0, 1'b1, cep_pkg::OFS_DIRECTION, 4'h0);
      op(1'b0, 1'b1, cep_pkg::OFS_SHARED_DATA, 4'h0);
      for (int j = 0; j < 6; j++) begin
        r = $random(seed);
        ext <= r[3:0];
        ext_en <= r[7:4];
        pd_opt <= r[11:8];
        c1o <= r[12];
        c2o <= r[13];
        // Amplifier mode keeps pin 1 an input
        op(1'b1, 1'b0, cep_pkg::OFS_DIRECTION, r[19:16] & (opt[5] ? 4'hd : 4'hf));
        op(1'b1, 1'b0, j[0] ? cep_pkg::OFS_INPUT_DATA : cep_pkg::OFS_SHARED_DATA,
          r[23:20]);
        op(1'b0, 1'b1, cep_pkg::OFS_SHARED_DATA, 4'h0);
        op(1'b0, 1'b1, cep_pkg::OFS_INPUT_DATA, 4'h0);
        op(1'b1, 1'b0, cep_pkg::OFS_MODE_STATUS, r[27:24]);
        op(1'b0, 1'b1, cep_pkg::OFS_MODE_STATUS, 4'h0);
        op(1'b0, 1'b1, cep_pkg::OFS_DIRECTION, 4'h0);
        op(1'b0, 1'b1, 4'h7, 4'h0);
        op(1'b0, 1'b0, 4'h0, 4'h0);
      end
    end
    // Let the last read reach its compare
    repeat (2) @(posedge mclk);
    if (expq.size() != 0) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, expq.size(), 0);
    end
    end_sim();
  end
endmodule
